// >>> verilog/gsr_pkg.sv
// Functional notes
// R1 - status is read-only; any write clears all generated host interrupts
// R2 - bits 5:0 give free entries of 64-deep command FIFO; 0x3f empty, reset
// R3 - bit 6 is 0 during vertical retrace, 1 otherwise; resets to 1
// R4 - bit 7 is pixel engine pipeline busy only, not FIFO occupancy; reset 0
// R5 - bit 8 set when any texture unit part or its FIFOs is busy
// R6 - bit 9 set when any unit or FIFO is active; 0 only all idle
// R7 - bit 10 is 2D unit busy, resets to 0; bit 11 reserved reads zero
// R8 - bits 27:12 give memory FIFO free entries when enabled; 0xffff is empty
// R9 - bits 30:28 count pending buffer swaps: up on issue, down on completion
// R10 - bit 31 retrace interrupt flag is unimplemented and always reads zero
package gsr_pkg;

  localparam int unsigned GSR_AW = 12;

  localparam logic [GSR_AW-1:0] GSR_OFF_STATUS   = 12'h000;
  localparam logic [GSR_AW-1:0] GSR_OFF_INT_STAT = 12'h004;
  localparam logic [GSR_AW-1:0] GSR_OFF_INT_MASK = 12'h008;

  localparam logic [31:0] GSR_STATUS_RST    = 32'h0000007f;
  localparam logic [5:0]  GSR_CMD_FREE_EMPTY = 6'h3f;
  localparam logic [15:0] GSR_MEM_FREE_EMPTY = 16'hffff;
  localparam logic [2:0]  GSR_SWAP_RST       = 3'h0;
  localparam logic [2:0]  GSR_SWAP_MAX       = 3'h7;

  // interrupt status / mask bit positions
  localparam int unsigned GSR_IRQ_W         = 3;
  localparam int unsigned GSR_EVT_RETRACE   = 0;
  localparam int unsigned GSR_EVT_SWAP_DONE = 1;
  localparam int unsigned GSR_EVT_IDLE      = 2;
  localparam logic [GSR_IRQ_W-1:0] GSR_INT_RST = 3'h0;

  typedef struct packed {
    logic        pend_irq;
    logic [2:0]  swap_pending;
    logic [15:0] mem_free;
    logic        rsvd11;
    logic        busy_2d;
    logic        sys_busy;
    logic        texture_busy;
    logic        pixel_busy;
    logic        retrace_idle;
    logic [5:0]  cmd_free;
  } gsr_status_s;

  typedef struct packed {
    logic [5:0]  cmd_free;
    logic        pixel_engine_busy;
    logic        texture_engine_busy;
    logic        texture_fifo_busy;
    logic        busy_2d;
    logic        misc_busy;
    logic        mem_fifo_en;
    logic [15:0] mem_free;
    logic        swap_issue;
    logic        swap_done;
  } gsr_engine_s;

  function automatic logic gsr_any_busy(gsr_engine_s e, logic [2:0] swaps);
    gsr_any_busy = e.pixel_engine_busy | e.texture_engine_busy |
                   e.texture_fifo_busy | e.busy_2d | e.misc_busy |
                   (e.cmd_free != GSR_CMD_FREE_EMPTY) |
                   (e.mem_fifo_en & (e.mem_free != GSR_MEM_FREE_EMPTY)) |
                   (swaps != GSR_SWAP_RST);
  endfunction : gsr_any_busy

endpackage : gsr_pkg

// >>> verilog/gsr_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module gsr_sync2
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output var  logic q
);

  logic meta_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : gsr_sync2
`default_nettype wire

// >>> verilog/gsr_swap_counter.sv
`timescale 1ns/1ps
`default_nettype none
module gsr_swap_counter
  import gsr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       inc,
  input  wire logic       dec,
  output var  logic [2:0] count_r
);

  // saturates rather than wraps so a lost completion cannot fake idle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_r <= GSR_SWAP_RST;
    else if (inc && !dec && count_r != GSR_SWAP_MAX)
      count_r <= count_r + 3'h1; // R9
    else if (dec && !inc && count_r != GSR_SWAP_RST)
      count_r <= count_r - 3'h1; // R9
  end

endmodule : gsr_swap_counter
`default_nettype wire

// >>> verilog/gsr_status_top.sv
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module gsr_status_top
  import gsr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [GSR_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              retrace_active,
  input  wire gsr_engine_s       eng,
  output logic                   irq
);

  logic                 rst_n;
  logic                 retrace_s;
  logic                 retrace_d_r;
  logic [2:0]           swap_cnt;
  gsr_status_s          status_r;
  logic [GSR_IRQ_W-1:0] int_stat_r;
  logic [GSR_IRQ_W-1:0] int_mask_r;
  logic [GSR_IRQ_W-1:0] evt;
  logic [GSR_IRQ_W-1:0] clr;
  logic                 setup;
  logic                 access;
  logic                 wr;
  logic                 mapped;
  logic                 busy_now;

  // one write decode shared by the clear and mask paths
  function automatic logic wr_hit
  (
    input logic              w,
    input logic [GSR_AW-1:0] a,
    input logic [GSR_AW-1:0] off
  );
    return w && (a == off);
  endfunction : wr_hit

  gsr_sync2 u_rst_sync
  (
    .clk   (clk),
    .rst_n (reset_n),
    .d     (1'b1),
    .q     (rst_n)
  );

  // retrace comes from the monitor timing pins, not our clock
  gsr_sync2 u_retrace_sync
  (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (retrace_active),
    .q     (retrace_s)
  );

  gsr_swap_counter u_swap
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .inc     (eng.swap_issue),
    .dec     (eng.swap_done),
    .count_r (swap_cnt)
  );

  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wr     = access && pwrite;
  assign mapped = (paddr == GSR_OFF_STATUS) ||
                  (paddr == GSR_OFF_INT_STAT) ||
                  (paddr == GSR_OFF_INT_MASK);

  // no wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  assign busy_now = gsr_any_busy(eng, swap_cnt);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status_r <= GSR_STATUS_RST; // R2
    else
    begin
      status_r.cmd_free     <= eng.cmd_free; // R2
      status_r.retrace_idle <= !retrace_s; // R3
      status_r.pixel_busy   <= eng.pixel_engine_busy; // R4
      status_r.texture_busy <= eng.texture_engine_busy |
                               eng.texture_fifo_busy; // R5
      status_r.sys_busy     <= busy_now; // R6
      status_r.busy_2d      <= eng.busy_2d; // R7
      status_r.rsvd11       <= 1'b0; // R7
      status_r.mem_free     <= eng.mem_fifo_en ? eng.mem_free
                                               : 16'h0000; // R8
      status_r.swap_pending <= swap_cnt; // R9
      status_r.pend_irq     <= 1'b0; // R10
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      retrace_d_r <= 1'b0;
    else
      retrace_d_r <= retrace_s;
  end

  always_comb
  begin
    evt                    = '0;
    evt[GSR_EVT_RETRACE]   = retrace_s && !retrace_d_r;
    evt[GSR_EVT_SWAP_DONE] = eng.swap_done;
    evt[GSR_EVT_IDLE]      = status_r.sys_busy && !busy_now;
  end

  // writing the status word wipes every generated interrupt
  always_comb
  begin
    clr = '0;
    if (wr_hit(wr, paddr, GSR_OFF_STATUS))
      clr = '1; // R1
    else if (wr_hit(wr, paddr, GSR_OFF_INT_STAT))
      clr = pwdata[GSR_IRQ_W-1:0];
  end

  // a new event in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      int_stat_r <= GSR_INT_RST;
    else
      int_stat_r <= (int_stat_r & ~clr) | evt; // R1
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      int_mask_r <= GSR_INT_RST;
    else if (wr_hit(wr, paddr, GSR_OFF_INT_MASK))
      int_mask_r <= pwdata[GSR_IRQ_W-1:0];
  end

  assign irq = |(int_stat_r & int_mask_r);

  // read data is latched in setup so it is stable through access
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (setup && !pwrite)
    begin
      case (paddr)
        GSR_OFF_STATUS:   prdata <= status_r;
        GSR_OFF_INT_STAT: prdata <= {29'h0, int_stat_r};
        GSR_OFF_INT_MASK: prdata <= {29'h0, int_mask_r};
        default:          prdata <= 32'h00000000;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_write_clears_irq: assert property ( // R1
    (wr && paddr == GSR_OFF_STATUS && evt == '0) |=> (int_stat_r == '0 && !irq))
    else $error("status write did not clear interrupts");

  chk_cmd_free_read: assert property ( // R2
    (setup && !pwrite && paddr == GSR_OFF_STATUS)
      |=> prdata[5:0] == $past(status_r.cmd_free) && !pslverr)
    else $error("command FIFO free count read wrong");

  chk_retrace_level: assert property ( // R3
    retrace_active [*3] |=> !status_r.retrace_idle)
    else $error("retrace bit not low during retrace");

  chk_pixel_busy: assert property ( // R4
    $rose(eng.pixel_engine_busy) |=> status_r.pixel_busy)
    else $error("pixel busy bit did not follow engine");

  chk_texture_busy: assert property ( // R5
    (eng.texture_fifo_busy && !eng.texture_engine_busy)
      |=> status_r.texture_busy)
    else $error("texture FIFO activity not reported");

  chk_sys_idle: assert property ( // R6
    !status_r.sys_busy |-> $past(eng.cmd_free) == GSR_CMD_FREE_EMPTY
      && !$past(eng.pixel_engine_busy) && !$past(eng.busy_2d))
    else $error("system idle while a unit was busy");

  chk_busy_2d_rsvd: assert property ( // R7
    eng.busy_2d |=> status_r.busy_2d && !status_r.rsvd11)
    else $error("2D busy bit wrong");

  chk_mem_free_off: assert property ( // R8
    !eng.mem_fifo_en |=> status_r.mem_free == 16'h0000)
    else $error("memory FIFO field not zero when disabled");

  chk_swap_up: assert property ( // R9
    (eng.swap_issue && !eng.swap_done && swap_cnt != GSR_SWAP_MAX)
      |=> ##1 status_r.swap_pending == $past(swap_cnt, 2) + 3'h1)
    else $error("pending swap count did not advance");

  chk_irq_bit_zero: assert property ( // R10
    !status_r.pend_irq && !(access && paddr == GSR_OFF_STATUS && prdata[31]))
    else $error("unimplemented interrupt flag read as one");

  // status fields trail the engine by one cycle (the swap count by two), retrace by three
  chk_retrace_idle: assert property ( // R3
    !retrace_active [*3] |=> status_r.retrace_idle)
    else $error("retrace bit not high outside retrace");

  chk_pixel_no_fifo: assert property ( // R4
    (!eng.pixel_engine_busy && eng.cmd_free != GSR_CMD_FREE_EMPTY)
      |=> !status_r.pixel_busy)
    else $error("pixel busy bit followed FIFO occupancy");

  chk_texture_idle: assert property ( // R5
    !(eng.texture_engine_busy || eng.texture_fifo_busy)
      |=> !status_r.texture_busy)
    else $error("texture busy bit set while texture unit idle");

  chk_sys_busy_fifo: assert property ( // R6
    (eng.cmd_free != GSR_CMD_FREE_EMPTY) |=> status_r.sys_busy)
    else $error("system idle with command FIFO not empty");

  chk_sys_busy_swap: assert property ( // R6
    (swap_cnt != GSR_SWAP_RST) |=> status_r.sys_busy)
    else $error("system idle with buffer swaps pending");

  chk_busy_2d_idle: assert property ( // R7
    !eng.busy_2d |=> !status_r.busy_2d)
    else $error("2D busy bit set while 2D unit idle");

  chk_mem_free_on: assert property ( // R8
    eng.mem_fifo_en |=> status_r.mem_free == $past(eng.mem_free))
    else $error("memory FIFO free count not reported");

  // swap counter: lone pulses move it short of its ends, both together or none hold it
  chk_swap_down: assert property ( // R9
    (eng.swap_done && !eng.swap_issue && swap_cnt != GSR_SWAP_RST)
      |=> swap_cnt == $past(swap_cnt) - 3'h1)
    else $error("pending swap count did not drop");

  chk_swap_hold: assert property ( // R9
    (eng.swap_issue == eng.swap_done) |=> $stable(swap_cnt))
    else $error("pending swap count moved without a lone pulse");

  chk_swap_sat: assert property ( // R9
    (eng.swap_issue && swap_cnt == GSR_SWAP_MAX)
      |=> swap_cnt == GSR_SWAP_MAX)
    else $error("pending swap count wrapped past its top");

  // event latching; a set in the clearing cycle must survive
  chk_retrace_event: assert property ( // R3
    (retrace_s && !retrace_d_r) |=> int_stat_r[GSR_EVT_RETRACE])
    else $error("retrace start not latched as an event");

  chk_idle_event: assert property ( // R6
    $fell(status_r.sys_busy) |-> int_stat_r[GSR_EVT_IDLE])
    else $error("return to idle not latched as an event");

  chk_set_wins: assert property ( // R1
    (evt != '0) |=> (int_stat_r & $past(evt)) == $past(evt))
    else $error("event lost against a clear in the same cycle");

  chk_int_w1c: assert property ( // R1
    (wr && paddr == GSR_OFF_INT_STAT && evt == '0)
      |=> (int_stat_r & $past(pwdata[GSR_IRQ_W-1:0])) == '0)
    else $error("written ones did not clear event bits");

  chk_status_no_store: assert property ( // R1
    (wr && paddr == GSR_OFF_STATUS) |=> $stable(int_mask_r))
    else $error("status write changed the interrupt mask");

  chk_mask_write: assert property ( // R1
    (wr && paddr == GSR_OFF_INT_MASK)
      |=> int_mask_r == $past(pwdata[GSR_IRQ_W-1:0]))
    else $error("interrupt mask write did not land");

  // read path: data only moves on a read setup
  chk_prdata_hold: assert property ( // R2
    !(setup && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside a read setup");

  chk_bit31_any: assert property ( // R10
    (setup && !pwrite) |=> !prdata[31])
    else $error("bit 31 of a register read as one");

  cov_status_write: cover property (wr && paddr == GSR_OFF_STATUS && irq);
  cov_swap_full: cover property (swap_cnt == GSR_SWAP_MAX);
  cov_retrace_irq: cover property (evt[GSR_EVT_RETRACE] && irq);
  cov_unmapped: cover property (pslverr);
  cov_idle_event: cover property (evt[GSR_EVT_IDLE]);

endmodule : gsr_status_top
`default_nettype wire

// >>> tb/gsr_eng_model.sv
`timescale 1ns/1ps
`default_nettype none
module gsr_eng_model
  import gsr_pkg::*;
(
  input  wire logic        clk,
  input  wire gsr_engine_s want,
  input  wire logic        issue,
  input  wire logic        done,
  input  wire logic        rt_req,
  output var  gsr_engine_s eng = '0,
  output var  logic        retrace_active = 1'b0
);
  // levels move only at edges, as the engine's own flops would
  always @(posedge clk)
  begin
    eng <= gsr_engine_s'({want[29:2], issue, done});
    retrace_active <= rt_req;
  end
endmodule : gsr_eng_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import gsr_pkg::*;
  ;
  logic              clk = 0, reset_n = 0, psel = 0, penable = 0;
  logic              pwrite = 0, issue = 0, done = 0, rt = 0, err;
  logic [GSR_AW-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, rd, seed = 32'd8661;
  logic [31:0]       prdata;
  logic              pready, pslverr, irq, rt_act;
  gsr_engine_s       want, eng;
  int                n_fail = 0, cmp_count = 0, sw = 0;

  always #5 clk = ~clk;

  gsr_status_top dut_u (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .retrace_active(rt_act), .eng(eng), .irq(irq));
  gsr_eng_model eng_u (.clk(clk), .want(want), .issue(issue),
    .done(done), .rt_req(rt), .eng(eng), .retrace_active(rt_act));

  function automatic logic [31:0] xs;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [31:0] ex(gsr_engine_s e, int s, logic r);
    logic b;
    b = e.pixel_engine_busy | e.texture_engine_busy | e.busy_2d |
        e.texture_fifo_busy | e.misc_busy | (e.cmd_free != 6'h3f) |
        (e.mem_fifo_en & (e.mem_free != 16'hffff)) | (s != 0);
    return {1'b0, s[2:0], e.mem_fifo_en ? e.mem_free : 16'h0, 1'b0,
            e.busy_2d, b, e.texture_engine_busy | e.texture_fifo_busy,
            e.pixel_engine_busy, ~r, e.cmd_free};
  endfunction : ex

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // entered just after an edge; trailing edge keeps transfers apart
  task automatic apb(input logic w, input logic [GSR_AW-1:0] a,
                     input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : apb

  task automatic rdst;
    repeat (6) @(posedge clk);
    apb(0, GSR_OFF_STATUS, 32'h0);
    chk(rd, ex(want, sw, rt));
  endtask : rdst

  task automatic swp(input logic i);
    if (i) issue <= 1;
    else done <= 1;
    @(posedge clk);
    issue <= 0;
    done <= 0;
    @(posedge clk);
    if (i) sw = (sw < 7) ? sw + 1 : 7;
    else sw = (sw > 0) ? sw - 1 : 0;
  endtask : swp

  task automatic summarize;
    $display("fails=%0d compares=%0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize;
  end

  initial
  begin
    want = gsr_engine_s'({6'h3f, 24'h0});
    repeat (5) @(posedge clk);
    reset_n <= 1;
    repeat (3) @(posedge clk);
    apb(0, GSR_OFF_STATUS, 32'h0);
    chk(rd, 32'h0000007f);
    chk({30'h0, pready, err}, 32'h2);
    $display("test reset done");
    repeat (24)
    begin
      seed = xs();
      want <= gsr_engine_s'(seed[29:0]);
      rt <= seed[31];
      rdst;
    end
    $display("test fields done");
    want <= gsr_engine_s'({6'h3f, 24'h0});
    rt <= 0;
    repeat (8) swp(1);
    rdst;
    swp(0);
    rdst;
    repeat (6) swp(0);
    rdst;
    apb(0, GSR_OFF_INT_STAT, 32'h0);
    chk(rd & 32'h6, 32'h6);
    $display("test swaps done");
    apb(1, GSR_OFF_INT_STAT, 32'h7);
    apb(1, GSR_OFF_INT_MASK, 32'h1);
    rt <= 1;
    repeat (6) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(0, GSR_OFF_INT_STAT, 32'h0);
    chk(rd, 32'h1);
    apb(1, GSR_OFF_INT_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1, GSR_OFF_INT_MASK, 32'h1);
    apb(1, GSR_OFF_STATUS, xs());
    chk({31'h0, irq}, 32'h0);
    apb(0, GSR_OFF_INT_STAT, 32'h0);
    chk(rd, 32'h0);
    rdst;
    apb(0, 12'h00c, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test interrupts done");
    summarize;
  end
endmodule : tb
`default_nettype wire
